// ==== hdl/ife_bank_cfg.svh ====
`ifndef IFE_BANK_CFG_SVH
`define IFE_BANK_CFG_SVH

// register indices; byte address is four times the index
`define IFE_IDX_TMR_HI_EN   16'hFF18
`define IFE_IDX_PORT_FLAGS  16'hFF1A
`define IFE_IDX_TMR_LO_FLAGS 16'hFF1B
`define IFE_IDX_SER_FLAGS   16'hFF1C
`define IFE_IDX_CLK_FLAGS   16'hFF1D
`define IFE_IDX_TMR_HI_FLAGS 16'hFF1E
`define IFE_IDX_AUX_EN      16'hFF20
`define IFE_IDX_PRIO        16'hFF21
`define IFE_IDX_EVT_STATUS  16'hFF22
`define IFE_IDX_EVT_MASK    16'hFF23

// bus geometry
`define IFE_ADDR_W          18
`define IFE_IDX_W           16

// reset values
`define IFE_RST_EN8         8'h00
`define IFE_RST_FLAGS8      8'h00
`define IFE_RST_SER         6'h00
`define IFE_RST_CLK         4'h0
`define IFE_RST_AUX_EN      26'h0000000
`define IFE_RST_PRIO        16'h0000
`define IFE_RST_EVT         5'h00

// aux enable field positions
`define IFE_AUX_PORT_LSB    0
`define IFE_AUX_TLO_LSB     8
`define IFE_AUX_SER_LSB     16
`define IFE_AUX_CLK_LSB     22

// factor vector positions, lowest index wins a tie
`define IFE_NFACT           34
`define IFE_F_PORT          0
`define IFE_F_TLO           8
`define IFE_F_THI           16
`define IFE_F_SER           24
`define IFE_F_CLK           30

// answers
`define IFE_RESP_OKAY       2'h0
`define IFE_RESP_SLVERR     2'h2

`endif

// ==== hdl/ife_flag_enable_bank.sv ====
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ife_bank_cfg.svh"

// Functional notes
// - Each timer 4 to 7 enable bit is read/write and gates its own request.
// - The timer 4 to 7 enable byte resets to zero.
// - Eight port flags latch their port input event, bit n for input n.
// - Writing one to a flag clears it, writing zero leaves it alone.
// - Timer 0 to 3 underflow and match flags share one byte and set on their event.
// - Serial flags sit in bits 0 to 5 and bits 6 and 7 read zero.
// - Clock timer flags sit in bits 0 to 3 and the upper nibble reads zero.
// - Timer 4 to 7 flags share one byte, timer 7 match at bit 7, timer 4 match at bit 1.
// - Every flag resets to zero.
// - A request goes out only when its level is above the cpu level; level 0 never requests.
// - The highest level is served first, ties by fixed vector order.
module ife_flag_enable_bank (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [17:0]            s_axi_awaddr,
   input  wire logic [2:0]             s_axi_awprot,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [17:0]            s_axi_araddr,
   input  wire logic [2:0]             s_axi_arprot,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic [7:0]             port_event,
   input  wire logic [7:0]             timer_lo_event,
   input  wire logic [7:0]             timer_hi_event,
   input  wire logic [5:0]             serial_event,
   input  wire logic [3:0]             clock_event,
   input  wire ife_pkg::ife_level_t    cpu_level,
   output logic                        irq,
   output logic [1:0]                  cpu_req_level,
   output logic [5:0]                  cpu_req_vector
);
   import ife_pkg::*;

   ife_state_t                s_reg;
   ife_state_t                s_next;
   logic                      wr_go;
   logic                      ar_take;
   logic [`IFE_IDX_W-1:0]     wr_idx;
   logic [`IFE_IDX_W-1:0]     rd_idx;
   logic [`IFE_NFACT-1:0]     flag_vec;
   logic [`IFE_NFACT-1:0]     en_vec;
   logic [`IFE_NFACT-1:0]     pend_vec;
   logic [2*`IFE_NFACT-1:0]   lvl_vec;
   logic [1:0]                win_level;
   logic [5:0]                win_index;

   // priority system of a factor: 0 port, 1..4 timer pairs, 5/6 serial, 7 clock
   function automatic logic [2:0] factor_system(input int idx);
      if (idx < `IFE_F_TLO)
         return 3'h0;
      else if (idx < `IFE_F_SER)
         return 3'(1 + (idx - `IFE_F_TLO) / 4);
      else if (idx < `IFE_F_SER + 3)
         return 3'h5;
      else if (idx < `IFE_F_CLK)
         return 3'h6;
      else
         return 3'h7;
   endfunction

   // known register index, shared by read and write decode
   function automatic logic reg_known(input logic [`IFE_IDX_W-1:0] idx);
      case (idx)
         `IFE_IDX_TMR_HI_EN, `IFE_IDX_PORT_FLAGS, `IFE_IDX_TMR_LO_FLAGS,
         `IFE_IDX_SER_FLAGS, `IFE_IDX_CLK_FLAGS, `IFE_IDX_TMR_HI_FLAGS,
         `IFE_IDX_AUX_EN, `IFE_IDX_PRIO, `IFE_IDX_EVT_STATUS,
         `IFE_IDX_EVT_MASK: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // byte lane merge for the wider registers
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b])
            r[8*b +: 8] = new_v[8*b +: 8];
      end
      return r;
   endfunction

   // read word; unused upper bits read zero
   function automatic logic [31:0] read_word(input logic [`IFE_IDX_W-1:0] idx,
                                             input ife_state_t s);
      case (idx)
         `IFE_IDX_TMR_HI_EN:    return {24'h000000, s.tmr_hi_en};
         `IFE_IDX_PORT_FLAGS:   return {24'h000000, s.port_flags};
         `IFE_IDX_TMR_LO_FLAGS: return {24'h000000, s.tmr_lo_flags};
         `IFE_IDX_SER_FLAGS:    return {26'h0000000, s.ser_flags};
         `IFE_IDX_CLK_FLAGS:    return {28'h0000000, s.clk_flags};
         `IFE_IDX_TMR_HI_FLAGS: return {24'h000000, s.tmr_hi_flags};
         `IFE_IDX_AUX_EN:       return {6'h00, s.aux_en};
         `IFE_IDX_PRIO:         return {16'h0000, s.prio};
         `IFE_IDX_EVT_STATUS:   return {27'h0000000, s.evt_status};
         `IFE_IDX_EVT_MASK:     return {27'h0000000, s.evt_mask};
         default:               return 32'h00000000;
      endcase
   endfunction

   // bus strobes; a write runs once address and data are both held
   assign wr_go   = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
   assign ar_take = s_axi_arvalid && s_reg.arready;
   assign wr_idx  = s_reg.aw_addr[`IFE_ADDR_W-1:2];
   assign rd_idx  = s_axi_araddr[`IFE_ADDR_W-1:2];

   // flat flag and enable vectors in vector order
   // flag and enable both
   assign flag_vec = {s_reg.clk_flags, s_reg.ser_flags, s_reg.tmr_hi_flags,
                      s_reg.tmr_lo_flags, s_reg.port_flags};
   assign en_vec   = {s_reg.aux_en[`IFE_AUX_CLK_LSB +: 4], s_reg.aux_en[`IFE_AUX_SER_LSB +: 6],
                      s_reg.tmr_hi_en, s_reg.aux_en[`IFE_AUX_TLO_LSB +: 8],
                      s_reg.aux_en[`IFE_AUX_PORT_LSB +: 8]};
   assign pend_vec = flag_vec & en_vec;

   // per factor level from its system's priority field
   always_comb begin
      for (int i = 0; i < `IFE_NFACT; i++)
         lvl_vec[2*i +: 2] = s_reg.prio[2*factor_system(i) +: 2];
   end

   // level filter and highest level, fixed order on ties
   ife_prio_pick #(
      .NFACT (`IFE_NFACT),
      .IW    (6)
   ) u_pick (
      .pend      (pend_vec),
      .lvl       (lvl_vec),
      .cpu_level (cpu_level),
      .win_level (win_level),
      .win_index (win_index)
   );

   // next state: bus, flags, status, request
   always_comb begin
      logic [7:0] clr8;
      logic [4:0] rd_clr;
      logic [31:0] m;
      clr8   = 8'h00;
      rd_clr = 5'h00;
      m      = 32'h00000000;
      s_next = s_reg;
      // address and data taken in either order
      if (s_axi_awvalid && s_reg.awready) begin
         s_next.aw_have = 1'b1;
         s_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_reg.wready) begin
         s_next.w_have = 1'b1;
         s_next.w_data = s_axi_wdata;
         s_next.w_strb = s_axi_wstrb;
      end
      if (s_reg.bvalid && s_axi_bready)
         s_next.bvalid = 1'b0;
      // flags set from events first; clears only remove written ones
      // port flags, timer 0-3, timer 4-7
      s_next.port_flags   = s_reg.port_flags | port_event;
      s_next.tmr_lo_flags = s_reg.tmr_lo_flags | timer_lo_event;
      s_next.tmr_hi_flags = s_reg.tmr_hi_flags | timer_hi_event;
      // serial 6 bits, clock 4 bits
      s_next.ser_flags    = s_reg.ser_flags | serial_event;
      s_next.clk_flags    = s_reg.clk_flags | clock_event;
      if (wr_go) begin
         s_next.aw_have = 1'b0;
         s_next.w_have  = 1'b0;
         s_next.bvalid  = 1'b1;
         s_next.bresp   = reg_known(wr_idx) ? `IFE_RESP_OKAY : `IFE_RESP_SLVERR;
         // write one clears, an event in the same cycle wins
         clr8 = s_reg.w_strb[0] ? s_reg.w_data[7:0] : 8'h00;
         case (wr_idx)
            `IFE_IDX_TMR_HI_EN:
               if (s_reg.w_strb[0])
                  s_next.tmr_hi_en = s_reg.w_data[7:0];
            `IFE_IDX_PORT_FLAGS:
               s_next.port_flags = (s_reg.port_flags & ~clr8) | port_event;
            `IFE_IDX_TMR_LO_FLAGS:
               s_next.tmr_lo_flags = (s_reg.tmr_lo_flags & ~clr8) | timer_lo_event;
            `IFE_IDX_SER_FLAGS:
               s_next.ser_flags = (s_reg.ser_flags & ~clr8[5:0]) | serial_event;
            `IFE_IDX_CLK_FLAGS:
               s_next.clk_flags = (s_reg.clk_flags & ~clr8[3:0]) | clock_event;
            `IFE_IDX_TMR_HI_FLAGS:
               s_next.tmr_hi_flags = (s_reg.tmr_hi_flags & ~clr8) | timer_hi_event;
            `IFE_IDX_AUX_EN: begin
               m = lane_merge({6'h00, s_reg.aux_en}, s_reg.w_data, s_reg.w_strb);
               s_next.aux_en = m[25:0];
            end
            `IFE_IDX_PRIO: begin
               m = lane_merge({16'h0000, s_reg.prio}, s_reg.w_data, s_reg.w_strb);
               s_next.prio = m[15:0];
            end
            `IFE_IDX_EVT_MASK:
               if (s_reg.w_strb[0])
                  s_next.evt_mask = s_reg.w_data[4:0];
            default: ;
         endcase
      end
      // read: answer one cycle after the address is taken
      if (s_reg.rvalid && s_axi_rready)
         s_next.rvalid = 1'b0;
      if (ar_take) begin
         s_next.rvalid = 1'b1;
         s_next.rdata  = read_word(rd_idx, s_reg);
         s_next.rresp  = reg_known(rd_idx) ? `IFE_RESP_OKAY : `IFE_RESP_SLVERR;
         if (rd_idx == `IFE_IDX_EVT_STATUS)
            rd_clr = 5'h1F;
      end
      // sticky group status, read clears, a new event still lands
      s_next.evt_status = (s_reg.evt_status & ~rd_clr) |
                          {|clock_event, |serial_event, |timer_hi_event,
                           |timer_lo_event, |port_event};
      s_next.irq = |(s_next.evt_status & s_next.evt_mask);
      // one new address per side until the answer is gone
      s_next.awready    = !s_next.aw_have && !s_next.bvalid;
      s_next.wready     = !s_next.w_have && !s_next.bvalid;
      s_next.arready    = !s_next.rvalid;
      s_next.req_level  = win_level;
      s_next.req_vector = win_index;
      // enables and flags clear at reset
      if (!aresetn) begin
         s_next              = '0;
         s_next.tmr_hi_en    = `IFE_RST_EN8;
         s_next.port_flags   = `IFE_RST_FLAGS8;
         s_next.tmr_lo_flags = `IFE_RST_FLAGS8;
         s_next.tmr_hi_flags = `IFE_RST_FLAGS8;
         s_next.ser_flags    = `IFE_RST_SER;
         s_next.clk_flags    = `IFE_RST_CLK;
         s_next.aux_en       = `IFE_RST_AUX_EN;
         s_next.prio         = `IFE_RST_PRIO;
         s_next.evt_status   = `IFE_RST_EVT;
         s_next.evt_mask     = `IFE_RST_EVT;
      end
   end

   // single state register, synchronous reset folded in above
   always_ff @(posedge aclk) begin
      s_reg <= s_next;
   end

   // outputs straight from the state flops
   assign s_axi_awready  = s_reg.awready;
   assign s_axi_wready   = s_reg.wready;
   assign s_axi_bvalid   = s_reg.bvalid;
   assign s_axi_bresp    = s_reg.bresp;
   assign s_axi_arready  = s_reg.arready;
   assign s_axi_rvalid   = s_reg.rvalid;
   assign s_axi_rdata    = s_reg.rdata;
   assign s_axi_rresp    = s_reg.rresp;
   assign irq            = s_reg.irq;
   assign cpu_req_level  = s_reg.req_level;
   assign cpu_req_vector = s_reg.req_vector;

   // read of a given index: taken, then answered next cycle
   sequence seq_read_of(logic [`IFE_IDX_W-1:0] idx);
      ar_take && (rd_idx == idx) ##1 s_reg.rvalid;
   endsequence

   a_tmr_en_store: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && wr_idx == `IFE_IDX_TMR_HI_EN && s_reg.w_strb[0]
      |=> s_reg.tmr_hi_en == $past(s_reg.w_data[7:0]) && s_reg.bvalid)
      else $error("timer enable byte did not take written value");
   a_reset_clears: assert property (@(posedge aclk)
      !aresetn |=> s_reg.tmr_hi_en == 8'h00 && flag_vec == '0)
      else $error("enables or flags not zero after reset");
   a_port_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      port_event != 8'h00 |=> (s_reg.port_flags & $past(port_event)) == $past(port_event))
      else $error("port event not latched");
   a_w1c_port: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && wr_idx == `IFE_IDX_PORT_FLAGS && s_reg.w_strb[0] && port_event == 8'h00
      |=> s_reg.port_flags == ($past(s_reg.port_flags) & ~$past(s_reg.w_data[7:0])))
      else $error("port flag write one to clear wrong");
   a_tmr_lo_set: assert property (@(posedge aclk) disable iff (!aresetn)
      timer_lo_event != 8'h00
      |=> (s_reg.tmr_lo_flags & $past(timer_lo_event)) == $past(timer_lo_event))
      else $error("timer 0 to 3 flag not set");
   a_ser_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      seq_read_of(`IFE_IDX_SER_FLAGS) |-> s_reg.rdata[31:6] == 26'h0000000)
      else $error("serial flag upper bits not zero");
   a_clk_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      seq_read_of(`IFE_IDX_CLK_FLAGS) |-> s_reg.rdata[31:4] == 28'h0000000)
      else $error("clock flag upper bits not zero");
   a_tmr7_match: assert property (@(posedge aclk) disable iff (!aresetn)
      timer_hi_event[7] |=> s_reg.tmr_hi_flags[7] [*2])
      else $error("timer 7 match flag lost");
   a_req_above_cpu: assert property (@(posedge aclk) disable iff (!aresetn)
      s_reg.req_level != 2'h0 |-> s_reg.req_level > $past(cpu_level))
      else $error("request at or below cpu level");
   a_req_needs_en: assert property (@(posedge aclk) disable iff (!aresetn)
      s_reg.req_level != 2'h0
      |-> |($past(pend_vec) & ({{(`IFE_NFACT-1){1'b0}}, 1'b1} << s_reg.req_vector)))
      else $error("request without flag and enable");
   a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      s_reg.irq == |(s_reg.evt_status & s_reg.evt_mask))
      else $error("irq disagrees with masked status");
endmodule

// ==== hdl/ife_pkg.sv ====
package ife_pkg;
   // complete state of the bank, one flop group
   typedef struct packed {
      logic [7:0]  tmr_hi_en;
      logic [7:0]  port_flags;
      logic [7:0]  tmr_lo_flags;
      logic [5:0]  ser_flags;
      logic [3:0]  clk_flags;
      logic [7:0]  tmr_hi_flags;
      logic [25:0] aux_en;
      logic [15:0] prio;
      logic [4:0]  evt_status;
      logic [4:0]  evt_mask;
      logic        irq;
      logic [1:0]  req_level;
      logic [5:0]  req_vector;
      logic        awready;
      logic        wready;
      logic        aw_have;
      logic        w_have;
      logic [17:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } ife_state_t;

   typedef logic [1:0] ife_level_t;
endpackage

// ==== hdl/ife_prio_pick.sv ====
`timescale 1ns/1ps
// picks the pending factor with the highest level above the cpu level
module ife_prio_pick #(
   parameter int NFACT = 34,
   parameter int IW    = 6
) (
   input  wire logic [NFACT-1:0]   pend,
   input  wire logic [2*NFACT-1:0] lvl,
   input  wire ife_pkg::ife_level_t cpu_level,
   output logic [1:0]              win_level,
   output logic [IW-1:0]           win_index
);
   import ife_pkg::*;

   // index width must hold every factor
   if (NFACT < 2 || NFACT > (1 << IW))
      $error("ife_prio_pick: NFACT does not fit IW");

   // descending scan with >= lets the lowest index win a tie
   always_comb begin
      win_level = 2'h0;
      win_index = '0;
      for (int i = NFACT - 1; i >= 0; i--) begin
         if (pend[i] && (lvl[2*i +: 2] > cpu_level) && (lvl[2*i +: 2] >= win_level)) begin
            win_level = lvl[2*i +: 2];
            win_index = IW'(i);
         end
      end
   end
endmodule

// ==== sim/ife_src_model.sv ====
`timescale 1ns/1ps
// peripheral event sources: each fire request becomes a one-cycle pulse
module ife_src_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        fire,
   input  wire logic [33:0] bits,
   output logic [7:0]       port_event,
   output logic [7:0]       timer_lo_event,
   output logic [7:0]       timer_hi_event,
   output logic [5:0]       serial_event,
   output logic [3:0]       clock_event
);
   // one pulse per event
   // pulses drop after one cycle, otherwise a held event would block every clear
   always_ff @(posedge aclk) begin
      if (!aresetn || !fire) begin
         {clock_event, serial_event, timer_hi_event, timer_lo_event, port_event} <= '0;
      end else begin
         {clock_event, serial_event, timer_hi_event, timer_lo_event, port_event} <= bits;
      end
   end
endmodule

// ==== sim/interrupt_flag_enable_bank_tb.sv ====
`timescale 1ns/1ps
`include "ife_bank_cfg.svh"
module interrupt_flag_enable_bank_tb;
   import ife_pkg::*;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire;
   logic [17:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic [33:0] fbits;
   ife_level_t  cpu_level;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0]  bresp, rresp, req_level;
   logic [31:0] rdata;
   logic [5:0]  req_vec;
   logic [7:0]  pev, tlev, thev;
   logic [5:0]  sev;
   logic [3:0]  cev;
   int          bad_count, compares;
   logic [31:0] seed;
   // flag groups: register index, position in the event vector, implemented bits
   logic [15:0] gidx [5] = '{`IFE_IDX_PORT_FLAGS, `IFE_IDX_TMR_LO_FLAGS,
                             `IFE_IDX_TMR_HI_FLAGS, `IFE_IDX_SER_FLAGS, `IFE_IDX_CLK_FLAGS};
   int          goff [5] = '{0, 8, 16, 24, 30};
   logic [7:0]  gmsk [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h0F};

   ife_flag_enable_bank u_ife_flag_enable_bank (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_event(pev),
      .timer_lo_event(tlev), .timer_hi_event(thev), .serial_event(sev),
      .clock_event(cev), .cpu_level(cpu_level), .irq(irq),
      .cpu_req_level(req_level), .cpu_req_vector(req_vec));

   ife_src_model u_ife_src_model (
      .aclk(aclk), .aresetn(aresetn), .fire(fire), .bits(fbits), .port_event(pev),
      .timer_lo_event(tlev), .timer_hi_event(thev), .serial_event(sev), .clock_event(cev));

   // 200 MHz clock
   always #2.5 aclk = ~aclk;

   // xorshift source, fixed seed keeps runs repeatable
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   // bus write: address and data offered together, each dropped when taken
   // answers are sampled at the falling edge, where they are settled, and acted on at the rise;
   // bready and rready stay high once raised, so no call lowers what the next one raises
   task automatic wr(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] r);
      int   n;
      logic aw_ok, w_ok, b_ok;
      n = 0;
      awaddr <= {idx, 2'b00};
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge aclk);
         aw_ok = awready;
         w_ok  = wready;
         b_ok  = bvalid;
         r     = bresp;
         @(posedge aclk);
         n++;
         if (aw_ok === 1'b1) awvalid <= 1'b0;
         if (w_ok === 1'b1) wvalid <= 1'b0;
      end while (b_ok !== 1'b1 && n < 50);
      if (n >= 50) chk(0, 1, "write answer missing");
   endtask

   task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
      int   n;
      logic ar_ok, r_ok;
      n = 0;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         ar_ok = arready;
         r_ok  = rvalid;
         d     = rdata;
         r     = rresp;
         @(posedge aclk);
         n++;
         if (ar_ok === 1'b1) arvalid <= 1'b0;
      end while (r_ok !== 1'b1 && n < 50);
      if (n >= 50) chk(0, 1, "read answer missing");
   endtask

   task automatic wok(input logic [15:0] idx, input logic [31:0] d);
      logic [1:0] r;
      wr(idx, d, r);
      chk({30'h0, r}, {30'h0, `IFE_RESP_OKAY}, "write response");
   endtask

   task automatic rchk(input logic [15:0] idx, input logic [31:0] exp, input string what);
      logic [31:0] d;
      logic [1:0]  r;
      rd(idx, d, r);
      chk({30'h0, r}, {30'h0, `IFE_RESP_OKAY}, "read response");
      chk(d, exp, what);
   endtask

   // one event pulse through the source model, then let flags settle
   task automatic pulse(input logic [33:0] b);
      fire <= 1'b1;
      fbits <= b;
      @(posedge aclk);
      fire <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask

   task automatic reqchk(input logic [1:0] lvl, input logic [5:0] vec);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk({30'h0, req_level}, {30'h0, lvl}, "request level");
      if (lvl != 2'd0) chk({26'h0, req_vec}, {26'h0, vec}, "request vector");
      @(posedge aclk);
   endtask

   // interrupt line looked at mid-cycle, away from the edge that launches it
   task automatic ichk(input logic exp, input string what);
      @(negedge aclk);
      chk({31'h0, irq}, {31'h0, exp}, what);
      @(posedge aclk);
   endtask

   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // watchdog: the whole sequence needs a few hundred cycles
   initial begin
      #100us;
      bad_count++;
      close_out();
   end

   initial begin
      logic [31:0] v, m;
      logic [1:0]  r;
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire} = '0;
      {awaddr, araddr, wdata, wstrb, fbits, cpu_level} = '0;
      {bad_count, compares} = '0;
      seed = 32'd66312;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // reset values
      rchk(`IFE_IDX_TMR_HI_EN, 0, "enable reset");
      for (int g = 0; g < 5; g++) rchk(gidx[g], 0, "flag reset");
      // enable byte keeps random values
      repeat (4) begin
         v = rnd();
         wok(`IFE_IDX_TMR_HI_EN, v);
         rchk(`IFE_IDX_TMR_HI_EN, v & 32'hFF, "enable readback");
      end
      // every group: all-ones corner first, then random sets and partial clears
      for (int g = 0; g < 5; g++) begin
         for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? {24'h0, gmsk[g]} : rnd() & {24'h0, gmsk[g]};
            m = rnd() & 32'hFF;
            pulse(34'(v) << goff[g]);
            rchk(gidx[g], v, "flag set");
            wok(gidx[g], m);
            rchk(gidx[g], v & ~m & 32'hFF, "flag partial clear");
            wok(gidx[g], 32'hFF);
            rchk(gidx[g], 0, "flag full clear");
         end
      end
      // unmapped place is refused both ways
      wr(16'h0010, 32'h5A, r);
      chk({30'h0, r}, {30'h0, `IFE_RESP_SLVERR}, "unmapped write");
      rd(16'h0010, v, r);
      chk({30'h0, r}, {30'h0, `IFE_RESP_SLVERR}, "unmapped read");
      // request routing: enable gating, level against cpu, winner choice
      wok(`IFE_IDX_TMR_HI_EN, 0);
      wok(`IFE_IDX_PRIO, 32'h00C2);
      wok(`IFE_IDX_AUX_EN, 32'hFF);
      cpu_level <= 2'd1;
      pulse((34'd1 << 5) | (34'd1 << 17));
      reqchk(2'd2, 6'd5);
      wok(`IFE_IDX_TMR_HI_EN, 32'h02);
      reqchk(2'd3, 6'd17);
      cpu_level <= 2'd3;
      reqchk(2'd0, 6'd0);
      cpu_level <= 2'd1;
      wok(`IFE_IDX_PRIO, 32'h00C3);
      reqchk(2'd3, 6'd5);
      wok(`IFE_IDX_PRIO, 0);
      cpu_level <= 2'd0;
      reqchk(2'd0, 6'd0);
      // interrupt line: masked group, unmasked group, clear on read
      wok(`IFE_IDX_PORT_FLAGS, 32'hFF);
      wok(`IFE_IDX_TMR_HI_FLAGS, 32'hFF);
      rd(`IFE_IDX_EVT_STATUS, v, r);
      wok(`IFE_IDX_EVT_MASK, 32'h01);
      pulse(34'd1 << 30);
      ichk(1'b0, "masked irq");
      pulse(34'd1 << 2);
      ichk(1'b1, "unmasked irq");
      rchk(`IFE_IDX_EVT_STATUS, 32'h11, "event status");
      repeat (2) @(posedge aclk);
      ichk(1'b0, "irq after status read");
      close_out();
   end
endmodule
